// ==== design/rts_pkg.sv ====
// Constants for the reload timer with frame capture
package rts_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_RELOAD_L = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_RELOAD_H = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_COUNT_L = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_COUNT_H = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_CLKCTL = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_INTCTL = 8'h18;
  localparam int unsigned CTL_FLAG_H = 7;
  localparam int unsigned CTL_FLAG_L = 6;
  localparam int unsigned CTL_LOW_IE = 5;
  localparam int unsigned CTL_SOF = 4;
  localparam int unsigned CTL_SPLIT = 3;
  localparam int unsigned CTL_RUN = 2;
  localparam int unsigned CTL_XCLK = 0;
  localparam int unsigned CLK_FAST_L = 0;
  localparam int unsigned CLK_FAST_H = 1;
  localparam int unsigned IE_TIMER = 0;
  localparam int unsigned IE_CAP = 1;
  localparam logic [7:0] BYTE_MAX = 8'hFF;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int unsigned SYS_DIV = 12;
  localparam int unsigned EXT_DIV = 8;
  localparam logic [3:0] SYS_DIV_LAST = 4'(SYS_DIV - 1);
  localparam logic [2:0] EXT_DIV_LAST = 3'(EXT_DIV - 1);
  localparam logic [3:0] SYS_DIV_ONE = 4'h1;
  localparam logic [2:0] EXT_DIV_ONE = 3'h1;
endpackage : rts_pkg

// ==== design/rts_prescaler.sv ====
// Divide-by-12 tick and synchronised external divide-by-8 tick
`timescale 1ns/1ps
module rts_prescaler (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ext_osc_in,
  output logic div12_tick,
  output logic ext8_tick
);
  logic [3:0] div_q, div_d;
  logic [2:0] ext_cnt_q, ext_cnt_d;
  logic meta_q, sync_q, prev_q;
  logic div_tick_q, div_tick_d, ext_tick_q, ext_tick_d;
  logic ext_rise;

  // Oscillator is asynchronous; the first stage is never looked at, only the second and third
  assign ext_rise = sync_q && !prev_q;

  always_comb begin
    div_d = div_q + rts_pkg::SYS_DIV_ONE;
    div_tick_d = (div_q == rts_pkg::SYS_DIV_LAST);
    if (div_q == rts_pkg::SYS_DIV_LAST) begin
      div_d = '0;
    end
    ext_cnt_d = ext_cnt_q;
    ext_tick_d = 1'b0;
    if (ext_rise) begin
      ext_cnt_d = ext_cnt_q + rts_pkg::EXT_DIV_ONE;
      ext_tick_d = (ext_cnt_q == rts_pkg::EXT_DIV_LAST);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= '0;
      ext_cnt_q <= '0;
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
      div_tick_q <= 1'b0;
      ext_tick_q <= 1'b0;
    end else begin
      div_q <= div_d;
      ext_cnt_q <= ext_cnt_d;
      meta_q <= ext_osc_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
      div_tick_q <= div_tick_d;
      ext_tick_q <= ext_tick_d;
    end
  end

  assign div12_tick = div_tick_q;
  assign ext8_tick = ext_tick_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  div12_period_a: assert property (div12_tick
    |=> !div12_tick [*8] ##1 !div12_tick [*3] ##1 div12_tick)
    else $error("divide-by-12 tick spacing wrong");
  ext8_count_a: assert property (ext8_tick
    |-> $past(ext_cnt_q) == rts_pkg::EXT_DIV_LAST && $past(ext_rise))
    else $error("external tick not on eighth synchronised edge");
endmodule : rts_prescaler

// ==== design/rts_timer.sv ====
// Reload timer with frame capture behind an AXI4-Lite slave
// Functional notes
// - Split and capture bits pick the mode
// - Count on clock, clock/12 or external/8
// - External divided tick synchronised to clock
// - 16-bit wrap reloads unless capture is on; sets high flag
// - 16-bit overflow interrupts when enabled
// - Low byte wrap interrupts if low enable
// - Split: two 8-bit reload counters
// - Split: run gates only high byte
// - Split: each byte has fast select
// - Split: each byte wrap sets own flag
// - Split: high, or either with low enable
// - Flags cleared only by software writes
// - Capture 16-bit count into reload on frame
// - Split capture copies both bytes on frame
//
// The address map and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
module rts_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sof_pulse,
  input wire logic ext_osc_in,
  output logic timer_irq
);
  // Bus slave state
  logic aw_full_q, aw_full_d, w_full_q, w_full_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [7:0] wbyte_q, wbyte_d;
  logic wlane_q, wlane_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  // Timer state
  logic flag_h_q, flag_h_d, flag_l_q, flag_l_d, low_ie_q, low_ie_d;
  logic sof_en_q, sof_en_d, split_q, split_d, run_q, run_d, xclk_q, xclk_d;
  logic fast_l_q, fast_l_d, fast_h_q, fast_h_d, tim_ie_q, tim_ie_d, cap_q, cap_d;
  logic [7:0] rl_l_q, rl_l_d, rl_h_q, rl_h_d, cnt_l_q, cnt_l_d, cnt_h_q, cnt_h_d;
  logic irq_q, irq_d;
  // Decode and count terms
  logic wr_fire, wr_ok, rd_fire;
  logic wr_ctl, wr_rl_l, wr_rl_h, wr_cnt_l, wr_cnt_h, wr_clk, wr_ie;
  logic div12_tick, ext8_tick, slow_tick, tick_l, tick_h;
  logic adv_l, adv_h, wrap_l, wrap_h, reload_ok, capture;
  logic [7:0] rd_byte;
  logic rd_ok;

  rts_prescaler u_prescaler (
    .aclk(aclk),
    .aresetn(aresetn),
    .ext_osc_in(ext_osc_in),
    .div12_tick(div12_tick),
    .ext8_tick(ext8_tick)
  );

  // Write fires once both halves are held and no response is pending
  assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
  assign wr_ok = wr_fire && wlane_q;
  assign wr_ctl = wr_ok && (awaddr_q == rts_pkg::OFF_CTRL);
  assign wr_rl_l = wr_ok && (awaddr_q == rts_pkg::OFF_RELOAD_L);
  assign wr_rl_h = wr_ok && (awaddr_q == rts_pkg::OFF_RELOAD_H);
  assign wr_cnt_l = wr_ok && (awaddr_q == rts_pkg::OFF_COUNT_L);
  assign wr_cnt_h = wr_ok && (awaddr_q == rts_pkg::OFF_COUNT_H);
  assign wr_clk = wr_ok && (awaddr_q == rts_pkg::OFF_CLKCTL);
  assign wr_ie = wr_ok && (awaddr_q == rts_pkg::OFF_INTCTL);
  assign rd_fire = s_axi_arvalid && !rvalid_q;

  // Clock source per byte; 16-bit modes use the low-byte select
  assign slow_tick = xclk_q ? ext8_tick : div12_tick;
  assign tick_l = fast_l_q || slow_tick;
  assign tick_h = fast_h_q || slow_tick;

  // Split low byte free-runs; everything else obeys run
  assign adv_l = split_q ? tick_l : (run_q && tick_l);
  assign wrap_l = adv_l && (cnt_l_q == rts_pkg::BYTE_MAX);
  assign adv_h = split_q ? (run_q && tick_h) : wrap_l;
  assign wrap_h = adv_h && (cnt_h_q == rts_pkg::BYTE_MAX);
  assign reload_ok = !sof_en_q;
  // Event arrives as a one-cycle pulse, so no edge detect here
  assign capture = sof_pulse && sof_en_q;

  always_comb begin
    cnt_l_d = cnt_l_q;
    cnt_h_d = cnt_h_q;
    if (adv_l) begin
      cnt_l_d = cnt_l_q + rts_pkg::BYTE_ONE;
      if (wrap_l && reload_ok && (split_q || wrap_h)) begin
        cnt_l_d = rl_l_q;
      end
    end
    if (adv_h) begin
      cnt_h_d = cnt_h_q + rts_pkg::BYTE_ONE;
      if (wrap_h && reload_ok) begin
        cnt_h_d = rl_h_q;
      end
    end
    // Software load of the count wins over counting
    if (wr_cnt_l) begin
      cnt_l_d = wbyte_q;
    end
    if (wr_cnt_h) begin
      cnt_h_d = wbyte_q;
    end
  end

  always_comb begin
    rl_l_d = wr_rl_l ? wbyte_q : rl_l_q;
    rl_h_d = wr_rl_h ? wbyte_q : rl_h_q;
    // Capture beats a software reload write in the same cycle
    if (capture) begin
      rl_l_d = cnt_l_q;
      rl_h_d = cnt_h_q;
    end
  end

  always_comb begin
    flag_h_d = wr_ctl ? wbyte_q[rts_pkg::CTL_FLAG_H] : flag_h_q;
    flag_l_d = wr_ctl ? wbyte_q[rts_pkg::CTL_FLAG_L] : flag_l_q;
    low_ie_d = wr_ctl ? wbyte_q[rts_pkg::CTL_LOW_IE] : low_ie_q;
    sof_en_d = wr_ctl ? wbyte_q[rts_pkg::CTL_SOF] : sof_en_q;
    split_d = wr_ctl ? wbyte_q[rts_pkg::CTL_SPLIT] : split_q;
    run_d = wr_ctl ? wbyte_q[rts_pkg::CTL_RUN] : run_q;
    xclk_d = wr_ctl ? wbyte_q[rts_pkg::CTL_XCLK] : xclk_q;
    fast_l_d = wr_clk ? wbyte_q[rts_pkg::CLK_FAST_L] : fast_l_q;
    fast_h_d = wr_clk ? wbyte_q[rts_pkg::CLK_FAST_H] : fast_h_q;
    tim_ie_d = wr_ie ? wbyte_q[rts_pkg::IE_TIMER] : tim_ie_q;
    cap_d = wr_ie ? wbyte_q[rts_pkg::IE_CAP] : cap_q;
    // Hardware sets win over a same-cycle software clear
    if (wrap_h) begin
      flag_h_d = 1'b1;
    end
    if (wrap_l) begin
      flag_l_d = 1'b1;
    end
    if (capture) begin
      cap_d = 1'b1;
    end
    irq_d = tim_ie_q && (flag_h_q || (low_ie_q && flag_l_q) || cap_q);
  end

  always_comb begin
    unique case (s_axi_araddr)
      rts_pkg::OFF_CTRL: rd_byte = {flag_h_q, flag_l_q, low_ie_q, sof_en_q, split_q, run_q,
                                    1'b0, xclk_q};
      rts_pkg::OFF_RELOAD_L: rd_byte = rl_l_q;
      rts_pkg::OFF_RELOAD_H: rd_byte = rl_h_q;
      rts_pkg::OFF_COUNT_L: rd_byte = cnt_l_q;
      rts_pkg::OFF_COUNT_H: rd_byte = cnt_h_q;
      rts_pkg::OFF_CLKCTL: rd_byte = {6'h00, fast_h_q, fast_l_q};
      rts_pkg::OFF_INTCTL: rd_byte = {6'h00, cap_q, tim_ie_q};
      default: rd_byte = rts_pkg::BYTE_RST;
    endcase
    rd_ok = (s_axi_araddr == rts_pkg::OFF_CTRL) || (s_axi_araddr == rts_pkg::OFF_RELOAD_L) ||
            (s_axi_araddr == rts_pkg::OFF_RELOAD_H) || (s_axi_araddr == rts_pkg::OFF_COUNT_L) ||
            (s_axi_araddr == rts_pkg::OFF_COUNT_H) || (s_axi_araddr == rts_pkg::OFF_CLKCTL) ||
            (s_axi_araddr == rts_pkg::OFF_INTCTL);
  end

  always_comb begin
    aw_full_d = aw_full_q;
    awaddr_d = awaddr_q;
    w_full_d = w_full_q;
    wbyte_d = wbyte_q;
    wlane_d = wlane_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_full_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_full_d = 1'b1;
      wbyte_d = s_axi_wdata[7:0];
      wlane_d = s_axi_wstrb[0];
    end
    if (wr_fire) begin
      aw_full_d = 1'b0;
      w_full_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = (wr_ctl || wr_rl_l || wr_rl_h || wr_cnt_l || wr_cnt_h || wr_clk || wr_ie ||
                 !wlane_q) ? rts_pkg::RESP_OKAY : rts_pkg::RESP_SLVERR;
      // Lane 0 off: nothing stored, still a clean answer
      if (!wlane_q) begin
        bresp_d = rts_pkg::RESP_OKAY;
      end
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (rd_fire) begin
      rvalid_d = 1'b1;
      rdata_d = {24'h000000, rd_byte};
      rresp_d = rd_ok ? rts_pkg::RESP_OKAY : rts_pkg::RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      awaddr_q <= '0;
      w_full_q <= 1'b0;
      wbyte_q <= rts_pkg::BYTE_RST;
      wlane_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= rts_pkg::RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= rts_pkg::RESP_OKAY;
      rdata_q <= '0;
      flag_h_q <= 1'b0;
      flag_l_q <= 1'b0;
      low_ie_q <= 1'b0;
      sof_en_q <= 1'b0;
      split_q <= 1'b0;
      run_q <= 1'b0;
      xclk_q <= 1'b0;
      fast_l_q <= 1'b0;
      fast_h_q <= 1'b0;
      tim_ie_q <= 1'b0;
      cap_q <= 1'b0;
      rl_l_q <= rts_pkg::BYTE_RST;
      rl_h_q <= rts_pkg::BYTE_RST;
      cnt_l_q <= rts_pkg::BYTE_RST;
      cnt_h_q <= rts_pkg::BYTE_RST;
      irq_q <= 1'b0;
    end else begin
      aw_full_q <= aw_full_d;
      awaddr_q <= awaddr_d;
      w_full_q <= w_full_d;
      wbyte_q <= wbyte_d;
      wlane_q <= wlane_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      flag_h_q <= flag_h_d;
      flag_l_q <= flag_l_d;
      low_ie_q <= low_ie_d;
      sof_en_q <= sof_en_d;
      split_q <= split_d;
      run_q <= run_d;
      xclk_q <= xclk_d;
      fast_l_q <= fast_l_d;
      fast_h_q <= fast_h_d;
      tim_ie_q <= tim_ie_d;
      cap_q <= cap_d;
      rl_l_q <= rl_l_d;
      rl_h_q <= rl_h_d;
      cnt_l_q <= cnt_l_d;
      cnt_h_q <= cnt_h_d;
      irq_q <= irq_d;
    end
  end

  assign s_axi_awready = !aw_full_q && !bvalid_q;
  assign s_axi_wready = !w_full_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign timer_irq = irq_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence quiet_s;
    !wr_ctl && !wr_ie;
  endsequence
  sequence cap_s;
    capture && tim_ie_q && !wr_ie;
  endsequence

  wrap16_reload_a: assert property (!split_q && !sof_en_q && wrap_h && !wr_cnt_l && !wr_cnt_h
    |=> {cnt_h_q, cnt_l_q} == $past({rl_h_q, rl_l_q}) && flag_h_q)
    else $error("16-bit wrap did not reload and flag");
  fast_count_a: assert property (!split_q && run_q && fast_l_q && !wrap_l && !wr_cnt_l
    |=> cnt_l_q == $past(cnt_l_q) + 8'h01)
    else $error("fast clock did not advance count");
  irq_high_a: assert property ((wrap_h && tim_ie_q && !wr_ie) ##1 quiet_s |=> timer_irq)
    else $error("overflow interrupt missing");
  irq_low_a: assert property ((wrap_l && tim_ie_q && low_ie_q && !wr_ie && !wr_ctl)
    ##1 quiet_s |=> timer_irq)
    else $error("low byte interrupt missing");
  split_reload_a: assert property (split_q && !sof_en_q && wrap_l && !wr_cnt_l
    |=> cnt_l_q == $past(rl_l_q) && flag_l_q)
    else $error("split low byte did not reload");
  split_run_a: assert property (split_q && !run_q && !wr_cnt_h |=> $stable(cnt_h_q))
    else $error("stopped high byte moved");
  split_fast_a: assert property (split_q && fast_l_q && !run_q && !wrap_l && !wr_cnt_l
    |=> cnt_l_q == $past(cnt_l_q) + 8'h01)
    else $error("split low byte did not free-run");
  split_flag_a: assert property (split_q && wrap_h |=> flag_h_q)
    else $error("high byte wrap did not flag");
  flag_hold_a: assert property (flag_h_q && !wr_ctl |=> flag_h_q)
    else $error("flag cleared without software");
  capture_a: assert property (capture |=> {rl_h_q, rl_l_q} == $past({cnt_h_q, cnt_l_q}))
    else $error("frame capture lost count");
  capture_irq_a: assert property (cap_s |=> ##1 timer_irq)
    else $error("capture interrupt missing");
endmodule : rts_timer

// ==== test/rts_sof_model.sv ====
// Frame-event source standing in for the bus controller
`timescale 1ns/1ps
module rts_sof_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic fire,
  output logic sof_pulse
);
  logic pulse_q;
  logic pulse_d;
  // Edge-detected so a held request still gives one cycle
  logic fire_q;
  always_comb begin
    pulse_d = aresetn && fire && !fire_q;
  end
  always_ff @(posedge aclk) begin
    pulse_q <= pulse_d;
    fire_q <= aresetn && fire;
  end
  assign sof_pulse = pulse_q;
endmodule : rts_sof_model

// ==== test/tb_top.sv ====
// Self-checking bench for the reload timer
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module tb_top;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic fire = 1'h0;
  logic ext_osc_in = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, sof_pulse, timer_irq;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rv;
  logic [2:0] ext_cnt = 3'h0;
  logic [7:0] c0;
  int failures = 0;
  int total_checks = 0;
  int i;
  // Rows: write, address, data, expected read byte, expected response
  logic [26:0] rows [9] = '{
    {1'h0, 8'h00, 8'h00, 8'h00, 2'h0}, {1'h1, 8'h04, 8'hA5, 8'h00, 2'h0},
    {1'h0, 8'h04, 8'h00, 8'hA5, 2'h0}, {1'h1, 8'h08, 8'h3C, 8'h00, 2'h0},
    {1'h0, 8'h08, 8'h00, 8'h3C, 2'h0}, {1'h1, 8'h00, 8'h02, 8'h00, 2'h0},
    {1'h0, 8'h00, 8'h00, 8'h00, 2'h0}, {1'h1, 8'h1C, 8'h55, 8'h00, 2'h2},
    {1'h0, 8'h1C, 8'h00, 8'h00, 2'h2}};
  always #5 aclk = ~aclk;
  // External oscillator at a quarter of the system rate
  always @(posedge aclk) begin
    ext_cnt <= ext_cnt + 3'h1;
    ext_osc_in <= ext_cnt[1];
  end
  rts_sof_model u_sof (.aclk(aclk), .aresetn(aresetn), .fire(fire), .sof_pulse(sof_pulse));
  rts_timer u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sof_pulse(sof_pulse), .ext_osc_in(ext_osc_in), .timer_irq(timer_irq));
  task automatic end_of_test;
    if (failures == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test
  // Ready is looked at on the falling edge, so it is what the next rising edge sees
  task automatic xf(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    logic ha, hw, hr, hb, hv;
    @(posedge aclk);
    if (w) begin
      awaddr <= a;
      wdata <= {24'h000000, d};
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
    end else begin
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
    end
    for (n = 0; n < 40; n++) begin
      @(negedge aclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hr = arvalid && arready;
      hb = bvalid;
      hv = rvalid;
      rv = rdata;
      rs = w ? bresp : rresp;
      @(posedge aclk);
      if (ha) awvalid <= 1'h0;
      if (hw) wvalid <= 1'h0;
      if (hr) arvalid <= 1'h0;
      if (hb || hv) begin
        bready <= 1'h0;
        rready <= 1'h0;
        break;
      end
    end
    if (n == 40) begin
      failures++;
      end_of_test();
    end
  endtask : xf
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xf(1'h1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    xf(1'h0, a, 8'h00);
  endtask : rd
  task automatic wait_irq(input int lim);
    int n;
    for (n = 0; n < lim; n++) begin
      @(negedge aclk);
      if (timer_irq === 1'h1) break;
    end
    if (n == lim) begin
      failures++;
      end_of_test();
    end
  endtask : wait_irq
  task automatic frame;
    @(posedge aclk);
    fire <= 1'h1;
    @(posedge aclk);
    fire <= 1'h0;
    repeat (3) @(posedge aclk);
  endtask : frame
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    for (i = 0; i < 9; i++) begin
      xf(rows[i][26], rows[i][25:18], rows[i][17:10]);
      if (!rows[i][26]) `CHK("table data", rows[i][9:2], rv[7:0])
      `CHK("table resp", rows[i][1:0], rs)
    end
    // 16-bit overflow near the top, reload 0xFFFE
    wr(8'h14, 8'h01);
    wr(8'h18, 8'h01);
    wr(8'h04, 8'hFE);
    wr(8'h08, 8'hFF);
    wr(8'h0C, 8'hF0);
    wr(8'h10, 8'hFF);
    wr(8'h00, 8'h04);
    wait_irq(100);
    rd(8'h00);
    `CHK("high flag", 1'h1, rv[7])
    rd(8'h10);
    `CHK("reloaded high", 8'hFF, rv[7:0])
    rd(8'h00);
    `CHK("flag kept", 1'h1, rv[7])
    // Stop first: a wrap in the clearing cycle would win over the clear
    wr(8'h00, 8'hC0);
    wr(8'h00, 8'h00);
    rd(8'h00);
    `CHK("flags cleared", 2'h0, rv[7:6])
    `CHK("irq after clear", 1'h0, timer_irq)
    // Low-byte wrap only interrupts with its enable
    wr(8'h10, 8'h00);
    wr(8'h0C, 8'hF8);
    wr(8'h00, 8'h04);
    repeat (40) @(negedge aclk);
    `CHK("no low irq", 1'h0, timer_irq)
    wr(8'h00, 8'h24);
    wait_irq(300);
    rd(8'h00);
    `CHK("low only", 2'h1, rv[7:6])
    // Split: low runs while run is off, high frozen
    wr(8'h00, 8'h08);
    wr(8'h04, 8'h80);
    wr(8'h10, 8'hFE);
    repeat (300) @(negedge aclk);
    rd(8'h10);
    `CHK("high held", 8'hFE, rv[7:0])
    rd(8'h0C);
    `CHK("low reload", 1'h1, rv[7])
    rd(8'h00);
    `CHK("split flags", 2'h1, rv[7:6])
    `CHK("low masked", 1'h0, timer_irq)
    wr(8'h14, 8'h03);
    wr(8'h00, 8'h0C);
    wait_irq(50);
    rd(8'h10);
    `CHK("high reload", 8'hFF, rv[7:0])
    rd(8'h00);
    `CHK("split high flag", 1'h1, rv[7])
    // Frame capture, stopped counter so the copy is known
    wr(8'h00, 8'h10);
    // High byte wrapped every cycle, so its flag survived the stop
    wr(8'h00, 8'h10);
    wr(8'h0C, 8'h34);
    wr(8'h10, 8'h12);
    `CHK("no irq before frame", 1'h0, timer_irq)
    frame();
    rd(8'h04);
    `CHK("capture low", 8'h34, rv[7:0])
    rd(8'h08);
    `CHK("capture high", 8'h12, rv[7:0])
    wait_irq(5);
    wr(8'h18, 8'h01);
    wr(8'h00, 8'h18);
    wr(8'h10, 8'h56);
    frame();
    rd(8'h08);
    `CHK("split capture", 8'h56, rv[7:0])
    // Slow rates: about ten ticks per measured window
    wr(8'h14, 8'h00);
    for (i = 0; i < 2; i++) begin
      wr(8'h00, i == 0 ? 8'h04 : 8'h05);
      rd(8'h0C);
      c0 = rv[7:0];
      repeat (i == 0 ? 120 : 320) @(negedge aclk);
      rd(8'h0C);
      `CHK("tick rate", 1'h1, (rv[7:0] - c0) inside {8'h09, 8'h0A, 8'h0B})
    end
    // Reset in mid-run: every register back to zero, no interrupt
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    for (i = 0; i < 7; i++) begin
      rd(8'(i * 4));
      `CHK("reset value", 8'h00, rv[7:0])
      `CHK("reset resp", 2'h0, rs)
    end
    `CHK("reset irq", 1'h0, timer_irq)
    end_of_test();
  end
endmodule : tb_top
